//--- hw/task_file_pkg.sv
// Purpose: Shared constants and types for the task-file status/control block
// Assumes: 100 MHz core clock, byte-wide task-file port with 4-bit offsets
// Notes:   Offsets, field positions, reset values and timing counts live here; drive address bit positions are set in task_file_ctrl

package task_file_pkg;

  // ****************************************************************
  // Register offsets on the task-file port
  // ****************************************************************
  localparam logic [3:0] OFF_ERROR        = 4'h1;
  localparam logic [3:0] OFF_SECTOR_COUNT = 4'h2;
  localparam logic [3:0] OFF_CYL_HIGH     = 4'h5;
  localparam logic [3:0] OFF_HEAD_SELECT  = 4'h6;
  localparam logic [3:0] OFF_STATUS       = 4'h7;
  localparam logic [3:0] OFF_MIRROR_CTRL  = 4'he;
  localparam logic [3:0] OFF_DRIVE_ADDR   = 4'hf;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int ST_BUSY = 7;
  localparam int ST_RDY  = 6;
  localparam int ST_DWF  = 5;
  localparam int ST_DSC  = 4;
  localparam int ST_DRQ  = 3;
  localparam int ST_CORRECTED_ERROR_FLAG = 2;
  localparam int ST_IDX  = 1;
  localparam int ST_ERR  = 0;
  localparam int CTL_SOFT_RESET = 2;
  localparam int CTL_INT_OFF    = 1;
  localparam int DH_LBA   = 6;
  localparam int DH_DRIVE = 4;
  localparam int ERR_ABORT = 2;

  // ****************************************************************
  // Reset and fixed values
  // ****************************************************************
  localparam logic [7:0] DH_ONES_MASK   = 8'ha0;
  localparam logic [7:0] DH_RESET       = 8'ha0;
  localparam logic [7:0] ERROR_RESET    = 8'h00;
  localparam logic [7:0] DIAG_NO_ERROR  = 8'h01;
  localparam logic [7:0] SECTOR_CNT_RST = 8'h01;
  localparam logic [7:0] BYTE_ZERO      = 8'h00;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS   = 10;
  localparam int BUSY_MAX_NS     = 400;
  localparam int BUF_CLASS2_US   = 700;
  localparam int BUF_CLASS3_MS   = 20;
  // Longest times round down
  localparam int BUSY_MAX_CYCLES = BUSY_MAX_NS / CLK_PERIOD_NS;
  localparam int BUF_CLASS2_CYCLES = (BUF_CLASS2_US * 1000) / CLK_PERIOD_NS;
  localparam int BUF_CLASS3_CYCLES = (BUF_CLASS3_MS * 1000000) / CLK_PERIOD_NS;
  localparam int TIMER_W = 22;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {CLASS_NONE, CLASS_1, CLASS_2, CLASS_3} cmd_class_e;

  typedef struct packed {
    logic       cs_n;
    logic       rd_n;
    logic       wr_n;
    logic [3:0] addr;
    logic [7:0] data;
  } host_bus_s;

endpackage

//--- hw/cmd_class_decode.sv
// Purpose: Maps a command code to its acceptance class
// Assumes: Pure combinational lookup, same clock as the caller
// Notes:   Unknown codes map to CLASS_NONE so the caller can abort them

`timescale 1ns/100ps
`default_nettype none

module cmd_class_decode (
  input  wire logic [7:0]               code,
  output var task_file_pkg::cmd_class_e cmd_class
);

  // ****************************************************************
  // Lookup table
  // ****************************************************************
  // Code lookup; wildcards cover the recalibrate and seek families
  always_comb begin
    casez (code)
      8'hc5, 8'hcd, 8'h3c:
        cmd_class = task_file_pkg::CLASS_3;
      8'h50, 8'he8, 8'hca, 8'h30, 8'h31, 8'h38:
        cmd_class = task_file_pkg::CLASS_2;
      8'he5, 8'h98, 8'hc0, 8'h90, 8'he7, 8'hec, 8'he3, 8'h97,
      8'he1, 8'h95, 8'h91, 8'h00, 8'he4, 8'hc8, 8'hc4, 8'hf8,
      8'h20, 8'h21, 8'h40, 8'h41, 8'h1?, 8'h03, 8'h7?, 8'hef,
      8'hf9, 8'hc6, 8'he6, 8'h99, 8'hb0, 8'he2, 8'h96, 8'he0,
      8'h94, 8'h87, 8'hf5:
        cmd_class = task_file_pkg::CLASS_1;
      default:
        cmd_class = task_file_pkg::CLASS_NONE;
    endcase
  end

endmodule

`default_nettype wire

//--- hw/task_file_ctrl.sv
// Purpose: Host-visible status, control and drive-select part of the task file
// Assumes: Host strobes are asynchronous pins; engine signals share CLK
// Notes:   Data register and command execution live in the media engine

`timescale 1ns/100ps
`default_nettype none

// Function
// - Head bit zero doubles as address bit 24
// - Status at 7h, mirror at Eh
// - Status read clears interrupt, mirror read does not
// - Busy denies host writes to command registers
// - Ready low until card accepts commands
// - Write fault flag; seek complete follows ready
// - Data request set for transfer, cleared next command
// - Corrected error flag, reads keep going
// - Index bit always reads zero
// - Error flag, failing address kept, cleared next command
// - Control register writable even while busy
// - Soft reset clears status, loads diagnostic code
// - Control bit one disables interrupt request
// - Read-only drive address register at Fh
// - Write gate reads low during writes
// - Inverted head bits and drive-selected bits
// - Class 1 sets busy within 400ns
// - Class 2 data request within 700us
// - Class 3 data request within 20ms
// - Command codes mapped to acceptance classes
// - Abort bit on invalid code or status
// - Drive bit must match configured drive number
module task_file_ctrl #(
  parameter int BUF2_CYCLES = task_file_pkg::BUF_CLASS2_CYCLES,
  parameter int BUF3_CYCLES = task_file_pkg::BUF_CLASS3_CYCLES
) (
  input  wire logic        CLK,
  input  wire logic        RSTN,
  input  wire logic        CE,
  input  wire logic        HOST_CS_N,
  input  wire logic        HOST_RD_N,
  input  wire logic        HOST_WR_N,
  input  wire logic [3:0]  HOST_ADDR,
  input  wire logic [7:0]  HOST_DATA_IN,
  output logic      [7:0]  HOST_DATA_OUT,
  output logic             HOST_DATA_OE,
  output logic             INTERRUPT_REQUEST_LINE_N,
  output logic             CFG_INT_DISABLE,
  output logic             SOFT_RESET,
  output logic             CMD_VALID,
  output logic      [7:0]  CMD_CODE,
  output logic      [1:0]  CMD_CLASS,
  output logic             LBA_MODE,
  output logic      [3:0]  HEAD_NUM,
  output logic      [3:0]  LBA_TOP,
  input  wire logic        CFG_DRIVE_NUM,
  input  wire logic        CARD_READY,
  input  wire logic        WRITE_ACTIVE,
  input  wire logic        WRITE_FAULT,
  input  wire logic        CORRECTED,
  input  wire logic        BUF_READY,
  input  wire logic        CMD_DONE,
  input  wire logic        CMD_ERR,
  input  wire logic [7:0]  CMD_ERR_BITS,
  input  wire logic [27:0] ERR_LBA
);

  // ****************************************************************
  // Host pin synchroniser
  // ****************************************************************
  typedef enum logic [1:0] {S_IDLE, S_BUSY, S_WAIT_BUF, S_XFER} cmd_state_e;

  task_file_pkg::host_bus_s   pin_bus;
  task_file_pkg::host_bus_s   sync1_reg, sync2_reg, prev_reg;
  task_file_pkg::cmd_class_e  dec_class;

  assign pin_bus = '{cs_n: HOST_CS_N, rd_n: HOST_RD_N, wr_n: HOST_WR_N,
                     addr: HOST_ADDR, data: HOST_DATA_IN};

  // Two flops, then a third copy for edge detection and the write address and data
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      sync1_reg <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: 4'h0, data: 8'h00};
      sync2_reg <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: 4'h0, data: 8'h00};
      prev_reg  <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: 4'h0, data: 8'h00};
    end else if (CE) begin
      sync1_reg <= pin_bus;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  // ****************************************************************
  // Task-file state
  // ****************************************************************
  cmd_state_e               state_reg, state_next;
  logic [7:0]               dh_reg, dh_next;
  logic [7:0]               cb_reg [0:3];
  logic [7:0]               cb_next [0:3];
  logic [7:0]               error_reg, error_next;
  logic                     ready_reg, ready_next;
  logic                     fault_reg, fault_next;
  logic                     drq_reg, drq_next;
  logic                     corrected_error_flag_reg, corrected_error_flag_next;
  logic                     err_reg, err_next;
  logic                     pend_reg, pend_next;
  logic                     nien_reg, nien_next;
  logic                     srst_reg, srst_next;
  logic [task_file_pkg::TIMER_W-1:0] timer_reg, timer_next;
  logic [7:0]               dout_next;
  logic                     oe_next;
  logic                     cmd_valid_next;
  logic [7:0]               cmd_code_next;
  logic [1:0]               cmd_class_next;
  logic                     rd_edge, wr_edge, rd_active, selected, busy;
  logic [7:0]               status, drive_addr;
  logic [3:0]               wr_addr;
  logic [7:0]               wr_data;

  cmd_class_decode u_decode (
    .code      (wr_data),
    .cmd_class (dec_class)
  );

  // Strobe edges; writes use the values held while the strobe was low
  assign rd_edge   = prev_reg.rd_n && !sync2_reg.rd_n && !sync2_reg.cs_n;
  assign wr_edge   = !prev_reg.wr_n && sync2_reg.wr_n && !prev_reg.cs_n;
  assign rd_active = !sync2_reg.cs_n && !sync2_reg.rd_n;
  assign wr_addr   = prev_reg.addr;
  assign wr_data   = prev_reg.data;
  assign selected  = (dh_reg[task_file_pkg::DH_DRIVE] == CFG_DRIVE_NUM);
  assign busy      = (state_reg == S_BUSY) || (state_reg == S_WAIT_BUF);

  // Status image; soft reset reads all zero
  always_comb begin
    status = 8'h00;
    if (!srst_reg) begin
      status[task_file_pkg::ST_BUSY] = busy;
      status[task_file_pkg::ST_RDY]  = ready_reg;
      status[task_file_pkg::ST_DWF]  = fault_reg;
      status[task_file_pkg::ST_DSC]  = ready_reg;
      status[task_file_pkg::ST_DRQ]  = drq_reg;
      status[task_file_pkg::ST_CORRECTED_ERROR_FLAG] = corrected_error_flag_reg;
      status[task_file_pkg::ST_IDX]  = 1'b0;
      status[task_file_pkg::ST_ERR]  = err_reg;
    end
  end

  // Drive address image; bit 7 is undefined and reads zero here
  always_comb begin
    drive_addr    = 8'h00;
    drive_addr[6] = !WRITE_ACTIVE;
    drive_addr[5:2] = ~dh_reg[3:0];
    drive_addr[1] = !(ready_reg && selected && CFG_DRIVE_NUM);
    drive_addr[0] = !(ready_reg && selected && !CFG_DRIVE_NUM);
  end

  // Next-state logic for the whole task file
  always_comb begin
    state_next     = state_reg;
    dh_next        = dh_reg;
    for (int i = 0; i < 4; i++) begin
      cb_next[i] = cb_reg[i];
    end
    error_next     = error_reg;
    ready_next     = CARD_READY && !srst_reg;
    fault_next     = fault_reg || WRITE_FAULT;
    drq_next       = drq_reg;
    corrected_error_flag_next      = corrected_error_flag_reg || CORRECTED;
    err_next       = err_reg;
    pend_next      = pend_reg;
    nien_next      = nien_reg;
    srst_next      = srst_reg;
    timer_next     = timer_reg;
    cmd_valid_next = 1'b0;
    cmd_code_next  = CMD_CODE;
    cmd_class_next = CMD_CLASS;
    dout_next      = HOST_DATA_OUT;
    oe_next        = rd_active && HOST_DATA_OE;

    // Host read: answer latched at the falling strobe edge
    if (rd_edge) begin
      oe_next   = selected || (sync2_reg.addr == task_file_pkg::OFF_HEAD_SELECT);
      dout_next = task_file_pkg::BYTE_ZERO;
      case (sync2_reg.addr)
        task_file_pkg::OFF_ERROR:       dout_next = error_reg;
        task_file_pkg::OFF_HEAD_SELECT: dout_next = dh_reg | task_file_pkg::DH_ONES_MASK;
        task_file_pkg::OFF_STATUS: begin
          dout_next = status;
          if (selected) begin
            pend_next = 1'b0;
          end
        end
        task_file_pkg::OFF_MIRROR_CTRL: dout_next = status;
        task_file_pkg::OFF_DRIVE_ADDR:  dout_next = drive_addr;
        default: begin
          if (sync2_reg.addr >= task_file_pkg::OFF_SECTOR_COUNT &&
              sync2_reg.addr <= task_file_pkg::OFF_CYL_HIGH) begin
            dout_next = cb_reg[2'(sync2_reg.addr - task_file_pkg::OFF_SECTOR_COUNT)];
          end
        end
      endcase
    end

    // Control register: always writable, upper bits ignored
    if (wr_edge && wr_addr == task_file_pkg::OFF_MIRROR_CTRL) begin
      nien_next = wr_data[task_file_pkg::CTL_INT_OFF];
      srst_next = wr_data[task_file_pkg::CTL_SOFT_RESET];
    end

    // Command block writes only when idle of busy
    if (wr_edge && !busy && !srst_reg) begin
      if (wr_addr == task_file_pkg::OFF_HEAD_SELECT) begin
        dh_next = wr_data | task_file_pkg::DH_ONES_MASK;
      end else if (selected && wr_addr >= task_file_pkg::OFF_SECTOR_COUNT &&
                   wr_addr <= task_file_pkg::OFF_CYL_HIGH) begin
        cb_next[2'(wr_addr - task_file_pkg::OFF_SECTOR_COUNT)] = wr_data;
      end else if (selected && wr_addr == task_file_pkg::OFF_STATUS) begin
        // New command clears the previous outcome
        drq_next   = 1'b0;
        err_next   = 1'b0;
        fault_next = WRITE_FAULT;
        corrected_error_flag_next  = CORRECTED;
        error_next = task_file_pkg::ERROR_RESET;
        if (dec_class == task_file_pkg::CLASS_NONE || !ready_reg) begin
          err_next   = 1'b1;
          error_next[task_file_pkg::ERR_ABORT] = 1'b1;
          pend_next  = 1'b1;
          state_next = S_IDLE;
        end else begin
          cmd_valid_next = 1'b1;
          cmd_code_next  = wr_data;
          cmd_class_next = dec_class;
          if (dec_class == task_file_pkg::CLASS_1) begin
            state_next = S_BUSY;
          end else begin
            state_next = S_WAIT_BUF;
            timer_next = (dec_class == task_file_pkg::CLASS_2) ?
                         task_file_pkg::TIMER_W'(BUF2_CYCLES) :
                         task_file_pkg::TIMER_W'(BUF3_CYCLES);
          end
        end
      end
    end

    // Engine progress
    case (state_reg)
      S_WAIT_BUF: begin
        if (BUF_READY) begin
          drq_next   = 1'b1;
          state_next = S_XFER;
        end else if (timer_reg == '0) begin
          // Buffer never came: abort so the host is not left hanging
          err_next   = 1'b1;
          error_next[task_file_pkg::ERR_ABORT] = 1'b1;
          pend_next  = 1'b1;
          state_next = S_IDLE;
        end else begin
          timer_next = timer_reg - 1'b1;
        end
      end
      S_BUSY, S_XFER: begin
        if (CMD_DONE) begin
          drq_next   = 1'b0;
          pend_next  = 1'b1;
          state_next = S_IDLE;
          if (CMD_ERR) begin
            err_next   = 1'b1;
            error_next = CMD_ERR_BITS;
            cb_next[1] = ERR_LBA[7:0];
            cb_next[2] = ERR_LBA[15:8];
            cb_next[3] = ERR_LBA[23:16];
            dh_next    = {dh_reg[7:4], ERR_LBA[27:24]};
          end
        end
      end
      S_IDLE: begin
        state_next = state_next;
      end
      default: state_next = S_IDLE;
    endcase

    // Soft reset overrides command state, status flags and error register while the bit stays high
    if (srst_next) begin
      state_next = S_IDLE;
      drq_next   = 1'b0;
      err_next   = 1'b0;
      fault_next = 1'b0;
      corrected_error_flag_next  = 1'b0;
      pend_next  = 1'b0;
      error_next = task_file_pkg::DIAG_NO_ERROR;
      cmd_valid_next = 1'b0;
    end
  end

  // Registers; outputs come straight from flops
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_reg <= S_IDLE;
      dh_reg    <= task_file_pkg::DH_RESET;
      cb_reg[0] <= task_file_pkg::SECTOR_CNT_RST;
      cb_reg[1] <= task_file_pkg::BYTE_ZERO;
      cb_reg[2] <= task_file_pkg::BYTE_ZERO;
      cb_reg[3] <= task_file_pkg::BYTE_ZERO;
      error_reg <= task_file_pkg::ERROR_RESET;
      ready_reg <= 1'b0;
      fault_reg <= 1'b0;
      drq_reg   <= 1'b0;
      corrected_error_flag_reg  <= 1'b0;
      err_reg   <= 1'b0;
      pend_reg  <= 1'b0;
      nien_reg  <= 1'b0;
      srst_reg  <= 1'b0;
      timer_reg <= '0;
      HOST_DATA_OUT   <= 8'h00;
      HOST_DATA_OE    <= 1'b0;
      INTERRUPT_REQUEST_LINE_N          <= 1'b1;
      CFG_INT_DISABLE <= 1'b0;
      SOFT_RESET      <= 1'b0;
      CMD_VALID       <= 1'b0;
      CMD_CODE        <= 8'h00;
      CMD_CLASS       <= 2'h0;
      LBA_MODE        <= 1'b0;
      HEAD_NUM        <= 4'h0;
      LBA_TOP         <= 4'h0;
    end else if (CE) begin
      state_reg <= state_next;
      dh_reg    <= dh_next;
      cb_reg    <= cb_next;
      error_reg <= error_next;
      ready_reg <= ready_next;
      fault_reg <= fault_next;
      drq_reg   <= drq_next;
      corrected_error_flag_reg  <= corrected_error_flag_next;
      err_reg   <= err_next;
      pend_reg  <= pend_next;
      nien_reg  <= nien_next;
      srst_reg  <= srst_next;
      timer_reg <= timer_next;
      HOST_DATA_OUT   <= dout_next;
      HOST_DATA_OE    <= oe_next;
      INTERRUPT_REQUEST_LINE_N          <= !(pend_next && !nien_next);
      CFG_INT_DISABLE <= nien_next;
      SOFT_RESET      <= srst_next;
      CMD_VALID       <= cmd_valid_next;
      CMD_CODE        <= cmd_code_next;
      CMD_CLASS       <= cmd_class_next;
      LBA_MODE        <= dh_next[task_file_pkg::DH_LBA];
      HEAD_NUM        <= dh_next[task_file_pkg::DH_LBA] ? 4'h0 : dh_next[3:0];
      LBA_TOP         <= dh_next[task_file_pkg::DH_LBA] ? dh_next[3:0] : 4'h0;
    end
  end

endmodule

`default_nettype wire

//--- testbench/task_file_ctrl_chk.sv
// Purpose: Port assertions for the task-file control block
// Assumes: One CLK domain, RSTN async active low, CE held high
// Notes:   Bound to every task_file_ctrl instance
`timescale 1ns/100ps
`default_nettype none
module task_file_ctrl_chk (
  input wire logic       CLK,
  input wire logic       RSTN,
  input wire logic       HOST_RD_N,
  input wire logic       HOST_WR_N,
  input wire logic       HOST_DATA_OE,
  input wire logic       INTERRUPT_REQUEST_LINE_N,
  input wire logic       CFG_INT_DISABLE,
  input wire logic       SOFT_RESET,
  input wire logic       CMD_VALID,
  input wire logic [1:0] CMD_CLASS,
  input wire logic       LBA_MODE,
  input wire logic [3:0] HEAD_NUM,
  input wire logic [3:0] LBA_TOP
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  logic [3:0] wr_age_reg;
  logic [3:0] wr_age_next;
  // Age of the last write strobe, saturating so it never wraps
  always_comb begin
    wr_age_next = (wr_age_reg == 4'hf) ? wr_age_reg : wr_age_reg + 4'h1;
    if (!HOST_WR_N) begin
      wr_age_next = 4'h0;
    end
  end
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      wr_age_reg <= 4'hf;
    end else begin
      wr_age_reg <= wr_age_next;
    end
  end
  // ****************************************************************
  // Properties
  // ****************************************************************
  property p_valid_pulse; CMD_VALID |=> !CMD_VALID; endproperty
  property p_valid_class; CMD_VALID |-> CMD_CLASS != 2'h0; endproperty
  property p_lba_head; LBA_MODE |-> HEAD_NUM == 4'h0; endproperty
  property p_chs_top; !LBA_MODE |-> LBA_TOP == 4'h0; endproperty
  property p_oe_release; HOST_RD_N [*5] |-> !HOST_DATA_OE; endproperty
  property p_int_gate; CFG_INT_DISABLE |-> INTERRUPT_REQUEST_LINE_N; endproperty
  property p_soft_irq; SOFT_RESET |=> INTERRUPT_REQUEST_LINE_N && !CMD_VALID; endproperty
  // Accepted command must follow a host write stroke closely
  property p_valid_cause; CMD_VALID |-> wr_age_reg < 4'h9; endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("command pulse too long");
  a_valid_class: assert property (p_valid_class) else $error("command without class");
  a_lba_head: assert property (p_lba_head) else $error("head bits in block mode");
  a_chs_top: assert property (p_chs_top) else $error("top bits in head mode");
  a_oe_release: assert property (p_oe_release) else $error("read data held too long");
  a_int_gate: assert property (p_int_gate) else $error("request while disabled");
  a_soft_irq: assert property (p_soft_irq) else $error("activity in soft reset");
  a_valid_cause: assert property (p_valid_cause) else $error("command without write");
  c_class3: cover property (CMD_VALID && CMD_CLASS == 2'h3);
  c_irq: cover property (!INTERRUPT_REQUEST_LINE_N);
  c_soft: cover property (SOFT_RESET);
endmodule
bind task_file_ctrl task_file_ctrl_chk u_chk (.CLK(CLK), .RSTN(RSTN), .HOST_RD_N(HOST_RD_N),
  .HOST_WR_N(HOST_WR_N), .HOST_DATA_OE(HOST_DATA_OE), .INTERRUPT_REQUEST_LINE_N(INTERRUPT_REQUEST_LINE_N),
  .CFG_INT_DISABLE(CFG_INT_DISABLE), .SOFT_RESET(SOFT_RESET), .CMD_VALID(CMD_VALID),
  .CMD_CLASS(CMD_CLASS), .LBA_MODE(LBA_MODE), .HEAD_NUM(HEAD_NUM), .LBA_TOP(LBA_TOP));
`default_nettype wire

//--- testbench/host_port_model.sv
// Purpose: Host controller driving the task-file pins
// Assumes: Strobes held well past the block's two-flop synchronisers
// Notes:   Released data shows the inverse of the last byte, never a stale copy
`timescale 1ns/100ps
`default_nettype none
module host_port_model (
  input  wire logic                    clk,
  input  wire logic [7:0]              dout,
  output var  task_file_pkg::host_bus_s bus
);
  initial bus = {1'b1, 1'b1, 1'b1, 4'h0, 8'h00};
  // Write: strobe low four cycles, select and data held past the rise
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= {1'b0, 1'b1, 1'b0, a, d};
    repeat (4) @(posedge clk);
    bus.wr_n <= 1'b1;
    repeat (2) @(posedge clk);
    bus <= {1'b1, 1'b1, 1'b1, a, ~d};
    repeat (6) @(posedge clk);
  endtask
  // Read: sample once the answer has had time to settle
  task automatic rd(input logic [3:0] a, output logic [7:0] q);
    @(posedge clk);
    bus <= {1'b0, 1'b0, 1'b1, a, ~bus.data};
    repeat (6) @(posedge clk);
    q = dout;
    bus.cs_n <= 1'b1;
    bus.rd_n <= 1'b1;
    repeat (5) @(posedge clk);
  endtask
endmodule
`default_nettype wire

//--- testbench/ata_task_file_status_control_tb.sv
// Purpose: Self-checking bench for the task-file control block
// Assumes: Engine side driven here, host side by host_port_model
// Notes:   Buffer timeouts shortened to 50 and 80 cycles
`timescale 1ns/100ps
`default_nettype none
module ata_task_file_status_control_tb;
  logic clk = 1'b0, rstn = 1'b0, rdy = 1'b0, wact = 1'b0, wf = 1'b0, corrected_error_flag = 1'b0;
  logic bufr = 1'b0, done = 1'b0, cerr = 1'b0, oe, irq_n, idis, srst, cval, lbam;
  logic [7:0] ebits = 8'h00, dout, ccode, v;
  logic [27:0] elba = 28'h0;
  logic [1:0] ccls;
  logic [3:0] head, ltop;
  task_file_pkg::host_bus_s hb;
  int fail_count = 0, num_checks = 0;
  logic [7:0] codes [14] = '{8'he5, 8'h98, 8'h20, 8'h90, 8'h00, 8'h50, 8'h30, 8'h38,
                             8'hca, 8'he8, 8'hc5, 8'hcd, 8'h3c, 8'h31};
  always #5 clk = ~clk;
  host_port_model u_host (.clk(clk), .dout(dout), .bus(hb));
  task_file_ctrl #(.BUF2_CYCLES(50), .BUF3_CYCLES(80)) u_dut (.CLK(clk), .RSTN(rstn),
    .CE(1'b1), .HOST_CS_N(hb.cs_n), .HOST_RD_N(hb.rd_n), .HOST_WR_N(hb.wr_n),
    .HOST_ADDR(hb.addr), .HOST_DATA_IN(hb.data), .HOST_DATA_OUT(dout), .HOST_DATA_OE(oe),
    .INTERRUPT_REQUEST_LINE_N(irq_n), .CFG_INT_DISABLE(idis), .SOFT_RESET(srst), .CMD_VALID(cval),
    .CMD_CODE(ccode), .CMD_CLASS(ccls), .LBA_MODE(lbam), .HEAD_NUM(head), .LBA_TOP(ltop),
    .CFG_DRIVE_NUM(1'b0), .CARD_READY(rdy), .WRITE_ACTIVE(wact), .WRITE_FAULT(wf),
    .CORRECTED(corrected_error_flag), .BUF_READY(bufr), .CMD_DONE(done), .CMD_ERR(cerr),
    .CMD_ERR_BITS(ebits), .ERR_LBA(elba));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
      fail_count++;
    end
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e,
                     input string what);
    logic [7:0] r;
    u_host.rd(a, r);
    check(what, r & m, e);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Class expected for each accepted code
  function automatic logic [1:0] class_of(input logic [7:0] c);
    case (c)
      8'hc5, 8'hcd, 8'h3c: class_of = 2'h3;
      8'h50, 8'h30, 8'h31, 8'h38, 8'hca, 8'he8: class_of = 2'h2;
      default: class_of = 2'h1;
    endcase
  endfunction
  task automatic eng_done(input logic e);
    cerr <= e;
    done <= 1'b1;
    @(posedge clk);
    cerr <= 1'b0;
    done <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  // One full command from issue to interrupt acknowledge
  task automatic run_cmd(input logic [7:0] c);
    u_host.wr(4'h7, c);
    rdc(4'h7, 8'h80, 8'h80, "busy");
    check("class", {6'h0, ccls}, {6'h0, class_of(c)});
    check("code", ccode, c);
    if (class_of(c) != 2'h1) begin
      bufr <= 1'b1;
      @(posedge clk);
      bufr <= 1'b0;
      rdc(4'h7, 8'hff, 8'h58, "drq");
    end
    eng_done(1'b0);
    rdc(4'he, 8'hff, 8'h50, "mirror");
    check("irq kept", {7'h0, irq_n}, 8'h00);
    rdc(4'h7, 8'hff, 8'h50, "status");
    check("irq cleared", {7'h0, irq_n}, 8'h01);
  endtask
  // Hang guard
  initial begin
    repeat (30000) @(posedge clk);
    fail_count++;
    summarize();
  end
  // Main sequence
  initial begin
    void'($urandom(43927));
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    rdc(4'h7, 8'hff, 8'h00, "not ready");
    rdy <= 1'b1;
    rdc(4'h7, 8'hff, 8'h50, "ready");
    for (int i = 0; i < 6; i++) begin
      v = 8'($urandom) & 8'hef;
      wact <= 1'($urandom);
      u_host.wr(4'h6, v);
      rdc(4'h6, 8'hff, v | 8'ha0, "head");
      check("mode", {7'h0, lbam}, {7'h0, v[6]});
      check("head", {4'h0, head}, v[6] ? 8'h00 : {4'h0, v[3:0]});
      check("lba top", {4'h0, ltop}, v[6] ? {4'h0, v[3:0]} : 8'h00);
      rdc(4'hf, 8'h7f, {1'b0, !wact, ~v[3:0], 2'b10}, "drive addr");
    end
    wact <= 1'b0;
    foreach (codes[i]) run_cmd(codes[i]);
    u_host.wr(4'h7, 8'h22);
    rdc(4'h7, 8'hff, 8'h51, "abort");
    rdc(4'h1, 8'h04, 8'h04, "abort bit");
    // Command while not ready, then a buffer that never comes
    rdy <= 1'b0;
    u_host.wr(4'h7, 8'h20);
    rdc(4'h7, 8'hff, 8'h01, "not ready abort");
    rdy <= 1'b1;
    u_host.wr(4'h7, 8'h30);
    repeat (50) @(posedge clk);
    rdc(4'h7, 8'hff, 8'h51, "buf timeout");
    rdc(4'h1, 8'hff, 8'h04, "timeout abort");
    u_host.wr(4'h6, 8'ha3);
    u_host.wr(4'h7, 8'h20);
    u_host.wr(4'h6, 8'he5);
    rdc(4'h6, 8'hff, 8'ha3, "busy lock");
    u_host.wr(4'he, 8'h04);
    check("soft", {7'h0, srst}, 8'h01);
    rdc(4'h7, 8'hff, 8'h00, "soft status");
    rdc(4'h1, 8'hff, 8'h01, "diag");
    u_host.wr(4'he, 8'h00);
    rdc(4'h7, 8'hff, 8'h50, "soft end");
    // Drive 1 addressed: command ignored, selected bits read high
    u_host.wr(4'h6, 8'hb0);
    u_host.wr(4'h7, 8'h20);
    rdc(4'h7, 8'h80, 8'h00, "unselected cmd");
    rdc(4'hf, 8'h03, 8'h03, "unselected addr");
    u_host.wr(4'h6, 8'ha0);
    u_host.wr(4'h7, 8'h20);
    elba <= 28'($urandom);
    ebits <= 8'h40;
    eng_done(1'b1);
    rdc(4'h7, 8'hff, 8'h51, "err");
    rdc(4'h1, 8'hff, 8'h40, "err reg");
    rdc(4'h3, 8'hff, elba[7:0], "fail addr");
    wf <= 1'b1;
    corrected_error_flag <= 1'b1;
    @(posedge clk);
    wf <= 1'b0;
    corrected_error_flag <= 1'b0;
    rdc(4'h7, 8'hff, 8'h75, "flags");
    run_cmd(8'h98);
    u_host.wr(4'he, 8'h02);
    check("int off", {7'h0, idis}, 8'h01);
    u_host.wr(4'h7, 8'h00);
    eng_done(1'b0);
    check("irq gated", {7'h0, irq_n}, 8'h01);
    u_host.wr(4'he, 8'h00);
    check("irq open", {7'h0, irq_n}, 8'h00);
    rdc(4'h7, 8'hff, 8'h50, "final");
    summarize();
  end
endmodule
`default_nettype wire
